// >>> common/setpoint_pkg.sv
// Package with constants for the thumbwheel setpoint reader.
package setpoint_pkg;
    // Number of thumbwheel channels.
    localparam int CHANNELS = 4;
    // Number of BCD digits per channel.
    localparam int DIGITS = 4;
    // Width of one channel value in bits.
    localparam int VALUE_W = 16;
    // Width of one data register.
    localparam int REG_W = 8;
    // Timer/counter preset references, first channel first.
    localparam logic [9:0] PRESET_REF_0 = 10'h2a2;
    localparam logic [9:0] PRESET_REF_1 = 10'h2a3;
    localparam logic [9:0] PRESET_REF_2 = 10'h2a4;
    localparam logic [9:0] PRESET_REF_3 = 10'h2a5;
    // Low data register of each channel pair; the high one is this plus one.
    localparam logic [9:0] DATA_REF_0 = 10'h234;
    localparam logic [9:0] DATA_REF_1 = 10'h236;
    localparam logic [9:0] DATA_REF_2 = 10'h23a;
    localparam logic [9:0] DATA_REF_3 = 10'h23c;
    // Reset value of a held preset.
    localparam logic [15:0] PRESET_RESET = 16'h0000;
    // Largest legal counter preset and smallest legal counter preset, in BCD.
    localparam logic [15:0] COUNT_MAX = 16'h9999;
    localparam logic [15:0] COUNT_MIN = 16'h0001;
    // Smallest timer preset in BCD tenths or hundredths.
    localparam logic [15:0] TIMER_MIN = 16'h0001;
endpackage : setpoint_pkg

// >>> common/channel_if.sv
// Interface carrying one channel's sampled value into its holding slot.
`timescale 1ns/1ps
interface channel_if;
    logic [15:0] raw; // Synchronised switch value.
    logic sample; // Scan strobe.
    logic [15:0] held; // Held preset value.
    logic digits_ok; // Every digit is a legal BCD code.
    modport src (output raw, output sample, input held, input digits_ok);
    modport slot (input raw, input sample, output held, output digits_ok);
endinterface : channel_if

// >>> rtl/setpoint_slot.sv
// One channel's holding slot: checks the BCD digits and keeps the preset.
`timescale 1ns/1ps
module setpoint_slot (
    input wire logic clk,
    input wire logic reset_n,
    channel_if.slot ch
);
    import setpoint_pkg::*;

    logic [15:0] held_q; // Held preset, kept until the next scan.
    logic [15:0] held_d; // Next held value.
    logic ok_q; // Digit check of the held value.
    logic ok_d; // Next digit check.

    // Check every nibble and take the value on the scan strobe.
    always_comb begin
        held_d = held_q;
        ok_d = ok_q;
        if (ch.sample) begin
            held_d = ch.raw;
            ok_d = 1'b1;
            for (int i = 0; i < DIGITS; i++) begin
                // A nibble above nine is not a legal digit.
                if (ch.raw[i*4 +: 4] > 4'h9) begin
                    ok_d = 1'b0;
                end
            end
        end
    end

    // Register the slot; reset clears the value and sets the digit check, the value then stays put.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_q <= PRESET_RESET;
            ok_q <= 1'b1;
        end else begin
            held_q <= held_d;
            ok_q <= ok_d;
        end
    end

    assign ch.held = held_q;
    assign ch.digits_ok = ok_q;

    // The slot takes exactly the value present at the scan strobe.
    AST_SLOT_TAKE: assert property (@(posedge clk) disable iff (!reset_n)
        ch.sample |=> held_q == $past(ch.raw))
        else $error("Slot did not take the scanned value.");
    // Without a scan the held value does not move.
    AST_SLOT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        !ch.sample |=> $stable(held_q))
        else $error("Held preset changed without a scan.");
endmodule : setpoint_slot

// >>> rtl/thumbwheel_bcd_setpoint_reader.sv
// Top of the thumbwheel setpoint reader: samples four banks each scan.
// Functional notes
// - Four channels, each into its own preset.
// - Data registers load together with the preset.
// - Presets stay held without switch unit.
// - Each preset reference holds one BCD value.
// - Channels one, two map to 564-567, 674-675.
// - Channels three, four map to 570-573, 676-677.
// - Registers eight bits; value spans two.
// - Rightmost switch position is least significant digit.
// - All channels sampled on every scan.
// - Standard timer: one implied decimal, 0.1-999.9.
// - Fine variant: two implied decimals, 0.01-99.99.
// - Counter preset is 1 through 9999.
`timescale 1ns/1ps
module thumbwheel_bcd_setpoint_reader #(
    parameter int NUM_CH = setpoint_pkg::CHANNELS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scan_strobe,
    input wire logic fine_res,
    input wire logic [63:0] switch_digits,
    input wire logic [9:0] rd_ref,
    output logic [15:0] preset_0,
    output logic [15:0] preset_1,
    output logic [15:0] preset_2,
    output logic [15:0] preset_3,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output logic [3:0] digits_ok,
    output logic [3:0] count_ok,
    output logic [3:0] timer_ok,
    output logic fine_res_q,
    output logic scan_done
);
    import setpoint_pkg::*;

    // Switch pins come from outside the clock domain, so two stages first.
    logic [63:0] sw_meta_q;
    logic [63:0] sw_sync_q;
    logic [63:0] sw_sync_d;
    logic fine_meta_q; // First stage of the resolution strap.
    logic fine_d; // Next resolution flag.

    // Output registers and their next values.
    logic [15:0] preset_q [NUM_CH];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_hit_q;
    logic rd_hit_d;
    logic [3:0] count_ok_q;
    logic [3:0] count_ok_d;
    logic [3:0] timer_ok_q;
    logic [3:0] timer_ok_d;
    logic [3:0] digits_ok_q;
    logic [3:0] digits_ok_d;
    logic done_q;
    logic done_d;
    logic [15:0] held [NUM_CH]; // Values kept by the slots.
    logic [NUM_CH-1:0] slot_ok; // Digit check per slot.

    // Data register table, index equals channel; the preset references need no decode.
    localparam logic [9:0] DATA_REF [4] = '{DATA_REF_0, DATA_REF_1,
                                            DATA_REF_2, DATA_REF_3};

    // One slot per channel, all strobed by the same scan.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        channel_if ch ();
        // Bank g sits in bits [16g+15:16g]; its low nibble is the rightmost wheel.
        assign ch.raw = sw_sync_q[g*16 +: 16];
        assign ch.sample = scan_strobe;
        assign held[g] = ch.held;
        assign slot_ok[g] = ch.digits_ok;
        setpoint_slot u_slot (
            .clk(clk),
            .reset_n(reset_n),
            .ch(ch)
        );
    end

    // Synchroniser next values: plain shift of the pins.
    always_comb begin
        sw_sync_d = sw_meta_q;
        fine_d = fine_meta_q;
    end

    // Synchroniser stages.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_meta_q <= 64'h0;
            sw_sync_q <= 64'h0;
            fine_meta_q <= 1'b0;
            fine_res_q <= 1'b0;
        end else begin
            sw_meta_q <= switch_digits;
            sw_sync_q <= sw_sync_d;
            fine_meta_q <= fine_res;
            fine_res_q <= fine_d;
        end
    end

    // Read decode and preset range checks.
    always_comb begin
        rd_data_d = 8'h00;
        rd_hit_d = 1'b0;
        count_ok_d = count_ok_q;
        timer_ok_d = timer_ok_q;
        digits_ok_d = slot_ok;
        done_d = scan_strobe;
        for (int i = 0; i < NUM_CH; i++) begin
            // Low register gives the two low digits, high register the top two.
            if (rd_ref == DATA_REF[i]) begin
                rd_data_d = held[i][7:0];
                rd_hit_d = 1'b1;
            end else if (rd_ref == DATA_REF[i] + 10'h001) begin
                rd_data_d = held[i][15:8];
                rd_hit_d = 1'b1;
            end
            // Counter preset must lie in 1..9999.
            count_ok_d[i] = slot_ok[i] && held[i] >= COUNT_MIN
                && held[i] <= COUNT_MAX;
            // Timer: 0001 is 0.1 s standard or 0.01 s fine; 9999 is the top.
            timer_ok_d[i] = slot_ok[i] && held[i] >= TIMER_MIN;
        end
    end

    // Output registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
            rd_hit_q <= 1'b0;
            count_ok_q <= 4'h0;
            timer_ok_q <= 4'h0;
            digits_ok_q <= 4'hf;
            done_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_hit_q <= rd_hit_d;
            count_ok_q <= count_ok_d;
            timer_ok_q <= timer_ok_d;
            digits_ok_q <= digits_ok_d;
            done_q <= done_d;
        end
    end

    // Presets come straight from the slot flip-flops at their references.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            preset_q[i] = held[i];
        end
    end

    assign preset_0 = preset_q[0];
    assign preset_1 = preset_q[1];
    assign preset_2 = preset_q[2];
    assign preset_3 = preset_q[3];
    assign rd_data = rd_data_q;
    assign rd_hit = rd_hit_q;
    assign count_ok = count_ok_q;
    assign timer_ok = timer_ok_q;
    assign digits_ok = digits_ok_q;
    assign scan_done = done_q;

    // Scan sequence: strobe, then preset shows the synchronised bank.
    sequence s_scan;
        scan_strobe;
    endsequence
    sequence s_loaded;
        ##1 preset_0 == $past(sw_sync_q[15:0]);
    endsequence

    AST_SCAN_LOAD0: assert property (@(posedge clk) disable iff (!reset_n)
        s_scan |-> s_loaded)
        else $error("Channel one not loaded on scan.");
    AST_SCAN_LOAD3: assert property (@(posedge clk) disable iff (!reset_n)
        scan_strobe |=> preset_3 == $past(sw_sync_q[63:48]))
        else $error("Channel four not loaded on scan.");
    AST_REG_LOW: assert property (@(posedge clk) disable iff (!reset_n)
        rd_ref == DATA_REF_0 |=> rd_hit && rd_data == $past(preset_0[7:0]))
        else $error("Low data register of channel one is wrong.");
    AST_REG_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
        rd_ref == DATA_REF_3 + 10'h001 |=> rd_hit && rd_data == $past(preset_3[15:8]))
        else $error("High data register of channel four is wrong.");
    AST_REG_GAP: assert property (@(posedge clk) disable iff (!reset_n)
        rd_ref == 10'h238 |=> !rd_hit && rd_data == 8'h00)
        else $error("Unused reference answered.");
    AST_REG_SAME: assert property (@(posedge clk) disable iff (!reset_n)
        scan_strobe ##1 rd_ref == DATA_REF_1 + 10'h001
        |=> rd_data == $past(preset_1[15:8]))
        else $error("Data register disagrees with preset.");
    AST_COUNT_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        preset_2 == 16'h0000 |=> !count_ok[2])
        else $error("Zero counter preset flagged legal.");
    AST_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        !scan_strobe [*2] |-> $stable(preset_1))
        else $error("Preset moved without a scan.");
    AST_DONE: assert property (@(posedge clk) disable iff (!reset_n)
        scan_strobe |=> scan_done)
        else $error("Scan done not raised.");
endmodule : thumbwheel_bcd_setpoint_reader

// >>> verif/thumbwheel_banks.sv
// Model of four hand-set four-digit BCD thumbwheel banks.
`timescale 1ns/1ps
module thumbwheel_banks (
    output logic [63:0] switch_digits
);
    // Dial setting of each bank; nibble 0 is the rightmost wheel.
    logic [15:0] wheel [4] = '{default: 16'h0000};
    // Turns one bank to a new setting at once; real wheels pass through steps.
    task automatic set_wheel(input int k, input logic [15:0] v);
        wheel[k] = v;
    endtask : set_wheel
    // Each bank drives its own sixteen pins, lowest digit on the lowest pins.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            switch_digits[16*k +: 16] = wheel[k];
        end
    end
endmodule : thumbwheel_banks

// >>> verif/test_thumbwheel_bcd_setpoint_reader.sv
// Self-checking bench for the thumbwheel setpoint reader.
`timescale 1ns/1ps
module test_thumbwheel_bcd_setpoint_reader;
    import setpoint_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic scan_strobe = 1'b0;
    logic fine_res = 1'b0;
    logic [9:0] rd_ref = 10'h000;
    logic [63:0] switch_digits;
    logic [15:0] preset [4];
    logic [7:0] rd_data;
    logic rd_hit;
    logic [3:0] digits_ok;
    logic [3:0] count_ok;
    logic [3:0] timer_ok;
    logic fine_res_q;
    logic scan_done;
    logic [15:0] want [4]; // Settings the bench dials in, per channel.
    logic [9:0] data_ref [4] = '{DATA_REF_0, DATA_REF_1, DATA_REF_2, DATA_REF_3};
    int fails = 0;
    int n_tests = 0;
    // Half period of the 200 MHz clock.
    always #2.5 clk = ~clk;
    thumbwheel_banks banks (.switch_digits(switch_digits));
    thumbwheel_bcd_setpoint_reader DUT (.clk(clk), .reset_n(reset_n),
        .scan_strobe(scan_strobe), .fine_res(fine_res), .switch_digits(switch_digits),
        .rd_ref(rd_ref), .preset_0(preset[0]), .preset_1(preset[1]), .preset_2(preset[2]),
        .preset_3(preset[3]), .rd_data(rd_data), .rd_hit(rd_hit), .digits_ok(digits_ok),
        .count_ok(count_ok), .timer_ok(timer_ok), .fine_res_q(fine_res_q),
        .scan_done(scan_done));
    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Moves inputs just after the rising edge so nothing races the sampling.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    // Dials the settings, lets the two-stage sync settle, strobes one scan.
    task automatic scan();
        for (int k = 0; k < 4; k++) begin
            banks.set_wheel(k, want[k]);
        end
        repeat (3) tick();
        scan_strobe = 1'b1;
        tick();
        scan_strobe = 1'b0;
        check("scan_done", 16'h0001, {15'h0000, scan_done});
        for (int k = 0; k < 4; k++) begin
            check("preset", want[k], preset[k]);
        end
    endtask : scan
    // Reads one data register; the byte answers one cycle later.
    task automatic read_reg(input logic [9:0] r, input logic hit, input logic [7:0] b);
        rd_ref = r;
        tick();
        check("rd_hit", {15'h0000, hit}, {15'h0000, rd_hit});
        check("rd_data", {8'h00, b}, {8'h00, rd_data});
    endtask : read_reg
    // Every channel lands in its own register pair, low digits in the low one.
    task automatic map_regs();
        want = '{16'h1234, 16'h5678, 16'h9012, 16'h3456};
        scan();
        // Read straight after the scan so the register shows the new preset at once.
        read_reg(data_ref[1] + 10'h001, 1'b1, want[1][15:8]);
        for (int k = 0; k < 4; k++) begin
            read_reg(data_ref[k], 1'b1, want[k][7:0]);
            read_reg(data_ref[k] + 10'h001, 1'b1, want[k][15:8]);
        end
        read_reg(10'h238, 1'b0, 8'h00);
        read_reg(PRESET_REF_0, 1'b0, 8'h00);
    endtask : map_regs
    // Turning the wheels without a scan leaves the held presets alone.
    task automatic hold_presets();
        for (int k = 0; k < 4; k++) begin
            banks.set_wheel(k, ~want[k] & 16'h7777);
        end
        repeat (8) tick();
        for (int k = 0; k < 4; k++) begin
            check("held", want[k], preset[k]);
        end
        want = '{16'h0707, 16'h7070, 16'h1111, 16'h2222};
        scan();
    endtask : hold_presets
    // Range flags at the edges of the counter and timer preset ranges.
    task automatic limits();
        logic [3:0] dig;
        logic [3:0] rng;
        want = '{16'h0000, 16'h0001, 16'h9999, 16'h99a9};
        for (int k = 0; k < 4; k++) begin
            dig[k] = 1'b1;
            for (int n = 0; n < 4; n++) begin
                dig[k] = dig[k] & (want[k][4*n +: 4] <= 4'h9);
            end
            rng[k] = dig[k] && want[k] >= COUNT_MIN && want[k] <= COUNT_MAX;
        end
        scan();
        repeat (2) tick();
        check("digits_ok", {12'h000, dig}, {12'h000, digits_ok});
        check("count_ok", {12'h000, rng}, {12'h000, count_ok});
        check("timer_ok", {12'h000, rng}, {12'h000, timer_ok});
        fine_res = 1'b1;
        repeat (3) tick();
        check("fine_res_q", 16'h0001, {15'h0000, fine_res_q});
        check("timer_fine", {12'h000, rng}, {12'h000, timer_ok});
    endtask : limits
    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // Cuts a hang short; the tests need well under a thousand cycles.
    initial begin
        #25000;
        fails++;
        end_sim();
    end
    // Main sequence: reset for sixteen cycles, then the scenarios.
    initial begin
        repeat (16) @(posedge clk);
        #1;
        check("reset_preset", PRESET_RESET, preset[0]);
        check("reset_digits", 16'h000f, {12'h000, digits_ok});
        check("reset_done", 16'h0000, {15'h0000, scan_done});
        reset_n = 1'b1;
        tick();
        map_regs();
        hold_presets();
        limits();
        end_sim();
    end
endmodule : test_thumbwheel_bcd_setpoint_reader
